/* verilog/fwps_map.svh */
// constants for the flash write-protection and status block
// assumes a 20 MHz system clock and a mode-0 serial host on the pins
//
// What this block does
// - The set-write-latch command sets the write-latch flag.
// - Reset, clear-write-latch and every accepted status write, page program or erase clear the latch.
// - With the latch clear, status writes, programs and erases are refused with no effect.
// - The busy flag is 1 exactly while a program, erase or status write runs.
// - The five protect-range bits are held as stored bits changed only by a status write or by reset.
// - Program and sector or block erase that touch the protected region are refused.
// - Whole-array erase runs only when the three low protect-range bits are all zero.
// - Protect-range and lock-mode bits change only while hardware protection is not in force.
// - In deep power-down every command but release-from-power-down is ignored.
// - Invert 0, top bit 0: codes 001 to 110 guard 64KB doubling to 2MB, top or bottom.
// - Invert 0: low code 000 guards nothing and 111 guards the whole array.
// - Invert 0, top bit 1: codes 001 to 011 guard 4, 8, 16KB, 10X and 110 guard 32KB.
// - For program and sector or block erase, invert 1 guards exactly the complement of the region chosen with invert 0.
// - Upper status byte holds erase-paused, invert, three OTP locks, program-paused, quad, lock-high.
// - Lock mode 00 free, 01 locked while guard pin low, 10 and 11 until power cycle.
`ifndef FWPS_MAP_SVH
`define FWPS_MAP_SVH

// ==========================================================================
// command codes
`define CMD_SET_LATCH      8'h06
`define CMD_CLEAR_LATCH    8'h04
`define CMD_STATUS_WRITE   8'h01
`define CMD_READ_STAT_LO   8'h05
`define CMD_READ_STAT_HI   8'h35
`define CMD_PAGE_PROGRAM   8'h02
`define CMD_SMALL_WIPE     8'h20
`define CMD_BLOCK32_WIPE   8'h52
`define CMD_BLOCK64_WIPE   8'hD8
`define CMD_ARRAY_WIPE_A   8'h60
`define CMD_ARRAY_WIPE_B   8'hC7
`define CMD_SLEEP          8'hB9
`define CMD_WAKE           8'hAB

// ==========================================================================
// status word layout
`define SW_BUSY            0
`define SW_LATCH           1
`define SW_PROT_LO         2
`define SW_PROT_HI         6
`define SW_LOCK_LO         7
`define SW_LOCK_HI         8
`define SW_QUAD            9
`define SW_PROG_PAUSED     10
`define SW_OTP_LO          11
`define SW_OTP_HI          13
`define SW_INVERT          14
`define SW_ERASE_PAUSED    15

// ==========================================================================
// frame byte counts
`define LEN_SHORT          3'h1
`define LEN_STAT_ONE       3'h2
`define LEN_STAT_TWO       3'h3
`define LEN_ERASE          3'h4
`define LEN_PROGRAM_MIN    3'h5
`define LEN_MAX            3'h7
`define LAST_BIT           3'h7

// ==========================================================================
// array geometry
`define ADDR_BITS          24
`define ARRAY_BYTES        23'h400000
`define SMALL_BYTES        23'h001000
`define LARGE_BYTES        23'h010000
`define SMALL_SHIFT_MAX    3'h3
`define PAGE_MASK          24'h0000FF
`define SECTOR_MASK        24'h000FFF
`define BLOCK32_MASK       24'h007FFF
`define BLOCK64_MASK       24'h00FFFF

// ==========================================================================
// lock-mode codes
`define LOCK_FREE          2'h0
`define LOCK_PIN           2'h1

// ==========================================================================
// operation times, microseconds, and clock rate
`define CLK_MHZ            20
`define T_PAGE_PROG_US     1000
`define T_SECTOR_WIPE_US   60000
`define T_BLOCK32_WIPE_US  300000
`define T_BLOCK64_WIPE_US  500000
`define T_ARRAY_WIPE_US    20000000
`define T_STATUS_WRITE_US  5000

`endif

/* verilog/fwps_pkg.sv */
// types shared by the write-protection and status block
// assumes the constant header is on the include path
`default_nettype none
`include "fwps_map.svh"

package fwps_pkg;

  // one-hot operating mode
  typedef enum logic [2:0]
  {
    FWPS_READY = 3'b001,
    FWPS_BUSY  = 3'b010,
    FWPS_SLEEP = 3'b100
  } fwps_mode_e;

  // every flop of the block
  typedef struct packed
  {
    logic [1:0]            sclk_sy;
    logic [1:0]            cs_sy;
    logic [1:0]            si_sy;
    logic [1:0]            wp_sy;
    logic                  sclk_prev;
    logic                  cs_prev;
    logic [7:0]            shift;
    logic [2:0]            bit_cnt;
    logic [2:0]            byte_cnt;
    logic [7:0]            opcode;
    logic [`ADDR_BITS-1:0] addr;
    logic [7:0]            new_lo;
    logic [7:0]            new_hi;
    logic [7:0]            tx;
    logic                  so;
    logic                  so_en;
    fwps_mode_e            mode;
    logic [31:0]           busy_left;
    logic                  latch;
    logic [4:0]            prot;
    logic                  invert;
    logic [1:0]            lock;
    logic                  quad;
    logic [2:0]            otp;
    logic                  reject;
  } fwps_state_s;

endpackage

`default_nettype wire

/* verilog/fwps_top.sv */
// write-protection, latch and status logic of a serial NOR flash
// assumes a mode-0 serial host; all pins are asynchronous to i_clk
`timescale 1ns/1ns
`default_nettype none
`include "fwps_map.svh"

module fwps_top
  import fwps_pkg::*;
#(
  parameter int unsigned PROG_CYC    = `T_PAGE_PROG_US * `CLK_MHZ,
  parameter int unsigned SECTOR_CYC  = `T_SECTOR_WIPE_US * `CLK_MHZ,
  parameter int unsigned BLOCK32_CYC = `T_BLOCK32_WIPE_US * `CLK_MHZ,
  parameter int unsigned BLOCK64_CYC = `T_BLOCK64_WIPE_US * `CLK_MHZ,
  parameter int unsigned ARRAY_CYC   = `T_ARRAY_WIPE_US * `CLK_MHZ,
  parameter int unsigned STATUS_CYC  = `T_STATUS_WRITE_US * `CLK_MHZ
)
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_si,
  input  wire logic        i_wp_n,
  output logic             o_so,
  output logic             o_so_oe,
  output logic [15:0]      o_status_word,
  output logic             o_busy,
  output logic             o_write_latch,
  output logic             o_deep_pd,
  output logic             o_cmd_reject
);

  fwps_state_s q;
  fwps_state_s d;

  // ========================================================================
  // protection region check
  // true when any byte of [first,last] is guarded by the range code
  function automatic logic prot_hit(input logic [`ADDR_BITS-1:0] first,
                                    input logic [`ADDR_BITS-1:0] last,
                                    input logic [4:0]            bp,
                                    input logic                  inv);
    logic [22:0] size;
    logic [22:0] plo;
    logic [22:0] phi;
    logic [22:0] f;
    logic [22:0] l;
    logic        empty;
    empty = (bp[2:0] == 3'h0);
    if (bp[2:0] == 3'h7)
      size = `ARRAY_BYTES;
    else if (bp[4])
      size = `SMALL_BYTES << ((bp[2:0] > `SMALL_SHIFT_MAX) ?
                              `SMALL_SHIFT_MAX : (bp[2:0] - 3'h1));
    else
      size = `LARGE_BYTES << (bp[2:0] - 3'h1);
    // bit 3 picks bottom of the array, else top
    plo = bp[3] ? 23'h000000 : (`ARRAY_BYTES - size);
    phi = plo + size - 23'h000001;
    f = {1'b0, first[21:0]};
    l = {1'b0, last[21:0]};
    if (!inv)
      prot_hit = !empty && (f <= phi) && (l >= plo);
    else
      prot_hit = empty || !((f >= plo) && (l <= phi));
  endfunction

  // status word as seen by reads and by the o_status_word port
  function automatic logic [15:0] pack_status(input fwps_state_s s);
    logic [15:0] w;
    w = 16'h0000;
    w[`SW_BUSY]                   = (s.mode == FWPS_BUSY);
    w[`SW_LATCH]                  = s.latch;
    w[`SW_PROT_HI:`SW_PROT_LO]    = s.prot;
    w[`SW_LOCK_LO]                = s.lock[0];
    w[`SW_LOCK_HI]                = s.lock[1];
    w[`SW_QUAD]                   = s.quad;
    w[`SW_PROG_PAUSED]            = 1'b0;                      // no suspend here
    w[`SW_OTP_HI:`SW_OTP_LO]      = s.otp;
    w[`SW_INVERT]                 = s.invert;
    w[`SW_ERASE_PAUSED]           = 1'b0;
    pack_status = w;
  endfunction

  // ========================================================================
  // pin view after synchronisers
  logic        sclk;
  logic        cs_n;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic [7:0]  in_byte;
  logic [7:0]  cur_op;
  logic [15:0] stat;
  logic        locked;
  logic        start;
  logic [31:0] dur;
  logic [`ADDR_BITS-1:0] mask;
  logic        needs_latch;

  // edges taken from the second stage only
  assign sclk      = q.sclk_sy[1];
  assign cs_n      = q.cs_sy[1];
  assign sclk_rise = sclk & ~q.sclk_prev & ~cs_n;
  assign sclk_fall = ~sclk & q.sclk_prev & ~cs_n;
  assign cs_fall   = q.cs_prev & ~cs_n;
  assign cs_rise   = ~q.cs_prev & cs_n;
  assign in_byte   = {q.shift[6:0], q.si_sy[1]};
  assign stat      = pack_status(q);

  // status writes locked by mode 10 and 11, or 01 with guard pin low
  assign locked = (q.lock != `LOCK_FREE) &&
                  !((q.lock == `LOCK_PIN) && q.wp_sy[1]);

  // ========================================================================
  // next-state logic
  always_comb
  begin
    d = q;
    d.reject  = 1'b0;
    start     = 1'b0;
    dur       = 32'(PROG_CYC);
    mask      = `PAGE_MASK;
    needs_latch = 1'b0;
    cur_op    = (q.byte_cnt == 3'h0) ? in_byte : q.opcode;
    // first stage feeds only the second
    d.sclk_sy   = {q.sclk_sy[0], i_sclk};
    d.cs_sy     = {q.cs_sy[0], i_cs_n};
    d.si_sy     = {q.si_sy[0], i_si};
    d.wp_sy     = {q.wp_sy[0], i_wp_n};
    d.sclk_prev = sclk;
    d.cs_prev   = cs_n;

    // frame opens: byte and bit counters restart
    if (cs_fall)
    begin
      d.bit_cnt  = 3'h0;
      d.byte_cnt = 3'h0;
      d.so_en    = 1'b0;
    end

    // input bit on each rising serial clock
    if (sclk_rise)
    begin
      d.shift   = in_byte;
      d.bit_cnt = q.bit_cnt + 3'h1;
      if (q.bit_cnt == `LAST_BIT)
      begin
        unique case (q.byte_cnt)
          3'h0: d.opcode = in_byte;
          3'h1:
          begin
            d.addr[23:16] = in_byte;
            d.new_lo      = in_byte;
          end
          3'h2:
          begin
            d.addr[15:8] = in_byte;
            d.new_hi     = in_byte;
          end
          3'h3: d.addr[7:0] = in_byte;
          default: ;
        endcase
        if (q.byte_cnt != `LEN_MAX)
          d.byte_cnt = q.byte_cnt + 3'h1;
        // status reads refresh at every byte so busy polling sees changes
        if (q.mode != FWPS_SLEEP)
        begin
          if (cur_op == `CMD_READ_STAT_LO)
          begin
            d.so_en = 1'b1;
            d.tx    = stat[7:0];
          end
          else if (cur_op == `CMD_READ_STAT_HI)
          begin
            d.so_en = 1'b1;
            d.tx    = stat[15:8];
          end
        end
      end
    end

    // output bit on each falling serial clock, msb first
    if (sclk_fall && q.so_en)
    begin
      d.so = q.tx[7];
      d.tx = {q.tx[6:0], 1'b0};
    end

    // operation timer; busy drops when it runs out
    if (q.mode == FWPS_BUSY)
    begin
      if (q.busy_left <= 32'h1)
        d.mode = FWPS_READY;
      else
        d.busy_left = q.busy_left - 32'h1;
    end

    // frame closes: act only on whole bytes, except wake in deep power-down
    if (cs_rise)
    begin
      d.so_en = 1'b0;
      if (q.mode == FWPS_SLEEP)
      begin
        // everything but wake is dropped
        if (q.opcode == `CMD_WAKE && q.byte_cnt != 3'h0)
          d.mode = FWPS_READY;
      end
      else if (q.mode == FWPS_READY && q.bit_cnt == 3'h0)
      begin
        unique case (q.opcode)
          `CMD_SET_LATCH:
            if (q.byte_cnt == `LEN_SHORT)
              d.latch = 1'b1;
          `CMD_CLEAR_LATCH:
            if (q.byte_cnt == `LEN_SHORT)
              d.latch = 1'b0;
          `CMD_SLEEP:
            if (q.byte_cnt == `LEN_SHORT)
              d.mode = FWPS_SLEEP;
          `CMD_STATUS_WRITE:
            if (q.byte_cnt == `LEN_STAT_ONE || q.byte_cnt == `LEN_STAT_TWO)
            begin
              needs_latch = 1'b1;
              if (!q.latch || locked)
                d.reject = 1'b1;
              else
              begin
                start       = 1'b1;
                dur         = 32'(STATUS_CYC);
                d.prot      = q.new_lo[`SW_PROT_HI:`SW_PROT_LO];
                d.lock[0]   = q.new_lo[`SW_LOCK_LO];
                if (q.byte_cnt == `LEN_STAT_TWO)
                begin
                  d.lock[1] = q.new_hi[`SW_LOCK_HI - 8];
                  d.quad    = q.new_hi[`SW_QUAD - 8];
                  d.invert  = q.new_hi[`SW_INVERT - 8];
                  // a status write only moves one-time bits from 0 to 1; reset clears them
                  d.otp     = q.otp | q.new_hi[`SW_OTP_HI-8:`SW_OTP_LO-8];
                end
              end
            end
          `CMD_PAGE_PROGRAM, `CMD_SMALL_WIPE, `CMD_BLOCK32_WIPE,
          `CMD_BLOCK64_WIPE:
          begin
            if (q.opcode == `CMD_PAGE_PROGRAM)
              needs_latch = (q.byte_cnt >= `LEN_PROGRAM_MIN);
            else
              needs_latch = (q.byte_cnt == `LEN_ERASE);
            unique case (q.opcode)
              `CMD_SMALL_WIPE:
              begin
                mask = `SECTOR_MASK;
                dur  = 32'(SECTOR_CYC);
              end
              `CMD_BLOCK32_WIPE:
              begin
                mask = `BLOCK32_MASK;
                dur  = 32'(BLOCK32_CYC);
              end
              `CMD_BLOCK64_WIPE:
              begin
                mask = `BLOCK64_MASK;
                dur  = 32'(BLOCK64_CYC);
              end
              default: ;
            endcase
            if (needs_latch)
            begin
              // refused commands leave latch and busy untouched
              if (!q.latch ||
                  prot_hit(q.addr & ~mask, q.addr | mask, q.prot, q.invert))
                d.reject = 1'b1;
              else
                start = 1'b1;
            end
          end
          `CMD_ARRAY_WIPE_A, `CMD_ARRAY_WIPE_B:
            if (q.byte_cnt == `LEN_SHORT)
            begin
              dur = 32'(ARRAY_CYC);
              if (!q.latch || q.prot[2:0] != 3'h0)
                d.reject = 1'b1;
              else
                start = 1'b1;
            end
          default: ;
        endcase
      end
    end

    // accepted write-type operation: busy on, latch off
    if (start)
    begin
      d.mode      = FWPS_BUSY;
      d.busy_left = dur;
      d.latch     = 1'b0;
    end
  end

  // ========================================================================
  // state register; reset stands in for a power cycle
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      q           <= '0;
      q.sclk_sy   <= 2'h0;
      q.cs_sy     <= 2'h3;
      q.cs_prev   <= 1'b1;
      q.mode      <= FWPS_READY;
      q.latch     <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // ========================================================================
  // outputs, all from flops
  assign o_so          = q.so;
  assign o_so_oe       = q.so_en;
  assign o_status_word = stat;
  assign o_busy        = (q.mode == FWPS_BUSY);
  assign o_write_latch = q.latch;
  assign o_deep_pd     = (q.mode == FWPS_SLEEP);
  assign o_cmd_reject  = q.reject;

endmodule

`default_nettype wire

/* tb/fwps_chk.sv */
// assertions on the pins of the write-protection and status block
// assumes a single clock domain and the asynchronous active-high reset
`timescale 1ns/1ns
`default_nettype none

module fwps_chk
#(
  parameter int unsigned PROG_CYC    = 20,
  parameter int unsigned SECTOR_CYC  = 20,
  parameter int unsigned BLOCK32_CYC = 20,
  parameter int unsigned BLOCK64_CYC = 20,
  parameter int unsigned ARRAY_CYC   = 20,
  parameter int unsigned STATUS_CYC  = 20
)
(
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_sclk,
  input wire logic        i_cs_n,
  input wire logic        i_si,
  input wire logic        i_wp_n,
  input wire logic        o_so,
  input wire logic        o_so_oe,
  input wire logic [15:0] o_status_word,
  input wire logic        o_busy,
  input wire logic        o_write_latch,
  input wire logic        o_deep_pd,
  input wire logic        o_cmd_reject
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // ==========================================================
  // busy length counter
  logic [31:0] busy_len_q;
  // busy cycles counted up to the previous clock edge; cleared one cycle after busy drops
  always_ff @(posedge i_clk or posedge i_sys_rst)
    if (i_sys_rst)
      busy_len_q <= 32'h0;
    else
      busy_len_q <= o_busy ? busy_len_q + 32'h1 : 32'h0;

  // ==========================================================
  // properties
  sequence op_start_s;
    $rose(o_busy);
  endsequence

  busy_length_a: assert property ($fell(o_busy) |-> busy_len_q inside
    {[PROG_CYC-1:PROG_CYC+1], [SECTOR_CYC-1:SECTOR_CYC+1], [BLOCK32_CYC-1:BLOCK32_CYC+1],
     [BLOCK64_CYC-1:BLOCK64_CYC+1], [ARRAY_CYC-1:ARRAY_CYC+1], [STATUS_CYC-1:STATUS_CYC+1]})
    else $error("busy flag stood for a wrong number of cycles");
  latch_cleared_a: assert property (op_start_s |-> !o_write_latch)
    else $error("latch still set after an operation started");
  latch_needed_a: assert property (op_start_s |-> $past(o_write_latch))
    else $error("operation started without the latch");
  reject_pulse_a: assert property (o_cmd_reject |=> !o_cmd_reject)
    else $error("reject flag longer than one cycle");
  reject_quiet_a: assert property (o_cmd_reject |-> !$rose(o_busy) [*2])
    else $error("busy rose on a refused command");
  prot_write_a: assert property ($changed(o_status_word[8:2]) |-> ##[0:1] o_busy)
    else $error("protect or lock bits changed outside a status write");
  guard_pin_a: assert property ((o_status_word[8:7] == 2'h1 && !i_wp_n) [*4]
    |=> $stable(o_status_word[8:2])) else $error("bits changed with guard pin low");
  lock_hold_a: assert property (o_status_word[8] |=> $stable(o_status_word[8:2]))
    else $error("locked status bits changed");
  sleep_quiet_a: assert property (o_deep_pd && $past(o_deep_pd)
    |-> $stable(o_write_latch) && !o_so_oe) else $error("activity in deep power-down");
  flag_map_a: assert property (o_status_word[1:0] == {o_write_latch, o_busy}
    && !o_status_word[15] && !o_status_word[10]) else $error("status flag mapping wrong");
endmodule

bind fwps_top fwps_chk #(.PROG_CYC(PROG_CYC), .SECTOR_CYC(SECTOR_CYC),
  .BLOCK32_CYC(BLOCK32_CYC), .BLOCK64_CYC(BLOCK64_CYC), .ARRAY_CYC(ARRAY_CYC),
  .STATUS_CYC(STATUS_CYC)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_si(i_si), .i_wp_n(i_wp_n), .o_so(o_so),
  .o_so_oe(o_so_oe), .o_status_word(o_status_word), .o_busy(o_busy),
  .o_write_latch(o_write_latch), .o_deep_pd(o_deep_pd), .o_cmd_reject(o_cmd_reject));

`default_nettype wire

/* tb/fwps_host.sv */
// host-side model: drives mode-0 serial frames into the flash block
// assumes the bench clock; every pin change lands on its rising edge
`timescale 1ns/1ns
`default_nettype none

module fwps_host
(
  input  wire logic i_clk,
  input  wire logic i_so,
  output var logic  o_sclk,
  output var logic  o_cs_n,
  output var logic  o_si
);
  // ==========================================================
  // pacing
  int half = 4; // clk per sclk half period; raise it for a slow host

  // serial clock rests low outside frames
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // ==========================================================
  // one frame: nbits of d msb first, then nrd bytes shifted into q
  task automatic frame(input logic [39:0] d, input int nbits, input int nrd,
                       output logic [7:0] q);
    q = 8'h00;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int k = 0; k < nbits + 8 * nrd; k++)
    begin
      o_si <= (k < nbits) ? d[nbits - 1 - k] : ~o_si; // toggles when unused
      tick(half);
      o_sclk <= 1'b1;
      #1 q = {q[6:0], i_so}; // read bit holds until the next fall
      tick(half);
      o_sclk <= 1'b0;
    end
    tick(half);
    o_cs_n <= 1'b1; // ends on a byte boundary so the command acts
    o_si   <= ~o_si; // a released line must not look settled
    tick(8);
  endtask
endmodule

`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the write-protection and status block
// assumes fwps_host drives the serial pins and fwps_chk is bound in
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  // ==========================================================
  // clock, reset and pins
  localparam int unsigned CYC = 20; // short operation times keep the run brief
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wp_n = 1'b1;
  logic        sclk;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        oe;
  logic [15:0] sw;
  logic        busy;
  logic        wl;
  logic        dpd;
  logic        rej;
  logic        rej_seen = 1'b0;
  logic        busy_seen = 1'b0;
  logic [7:0]  q;
  int          n_errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #25 clk = ~clk;

  fwps_top #(.PROG_CYC(CYC), .SECTOR_CYC(CYC), .BLOCK32_CYC(CYC), .BLOCK64_CYC(CYC),
    .ARRAY_CYC(CYC), .STATUS_CYC(CYC)) dut (.i_clk(clk), .i_sys_rst(rst),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .i_wp_n(wp_n), .o_so(so), .o_so_oe(oe),
    .o_status_word(sw), .o_busy(busy), .o_write_latch(wl), .o_deep_pd(dpd),
    .o_cmd_reject(rej));
  // an undriven output line reads as the inverse, so a late enable shows up as bad data
  fwps_host host (.i_clk(clk), .i_so(oe ? so : ~so), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));

  // ==========================================================
  // helpers
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // sticky copies of the short pulses, and the run ceiling
  always @(posedge clk)
  begin
    cycles++;
    if (rej === 1'b1) rej_seen <= 1'b1;
    if (busy === 1'b1) busy_seen <= 1'b1;
    if (cycles == 60000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one frame, then wait out any operation it started
  task automatic cmd(input logic [39:0] d, input int nbits);
    @(posedge clk);
    rej_seen  <= 1'b0;
    busy_seen <= 1'b0;
    host.frame(d, nbits, 0, q);
    for (int i = 0; i < 3 * CYC && busy !== 1'b0; i++) @(posedge clk);
    #1;
  endtask

  task automatic reset_pulse();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // set a protect code, then try one program or erase
  task automatic try(input logic [4:0] bp, input logic inv, input logic [7:0] op,
                     input logic [23:0] a, input logic exp_rej);
    cmd(40'h06, 8);
    cmd({8'h01, 1'b0, bp, 2'b00, 1'b0, inv, 6'h00}, 24);
    check(sw[14:2], {inv, 7'h00, bp}, "protect code");
    cmd(40'h06, 8);
    if (op == 8'h60 || op == 8'hC7) cmd({32'h0, op}, 8);
    else if (op == 8'h02) cmd({op, a, 8'hA5}, 40);
    else cmd({8'h00, op, a}, 32);
    check(rej_seen, exp_rej, "refusal");
    check(busy_seen, !exp_rej, "busy");
    check(wl, exp_rej, "latch after op");
  endtask

  // ==========================================================
  // scenarios
  initial
  begin
    reset_pulse();
    check(sw, 16'h0000, "word after reset");
    cmd(40'h06, 8);
    check(wl, 1'b1, "latch set");
    cmd(40'h04, 8);
    check(wl, 1'b0, "latch cleared");
    cmd({8'h02, 24'h000100, 8'h5A}, 40);
    check({rej_seen, busy_seen}, 2'b10, "program without latch");
    cmd({8'h01, 8'h1C}, 16);
    check(sw, 16'h0000, "status write without latch");
    try(5'h01, 1'b0, 8'h20, 24'h3F0000, 1'b1);
    try(5'h01, 1'b0, 8'h20, 24'h3EF000, 1'b0);
    try(5'h09, 1'b0, 8'h20, 24'h00F000, 1'b1);
    try(5'h09, 1'b0, 8'h20, 24'h010000, 1'b0);
    try(5'h06, 1'b0, 8'hD8, 24'h200000, 1'b1);
    try(5'h06, 1'b0, 8'h52, 24'h1F8000, 1'b0);
    try(5'h18, 1'b0, 8'h20, 24'h3FF000, 1'b0);
    try(5'h17, 1'b0, 8'h20, 24'h000000, 1'b1);
    try(5'h11, 1'b0, 8'h20, 24'h3FF000, 1'b1);
    try(5'h11, 1'b0, 8'h02, 24'h3FEF00, 1'b0);
    try(5'h13, 1'b0, 8'h02, 24'h3FC000, 1'b1);
    try(5'h15, 1'b0, 8'h52, 24'h3F0000, 1'b0);
    try(5'h1E, 1'b0, 8'h20, 24'h007000, 1'b1);
    try(5'h1E, 1'b0, 8'h20, 24'h008000, 1'b0);
    try(5'h01, 1'b1, 8'h20, 24'h3F0000, 1'b0);
    try(5'h01, 1'b1, 8'h20, 24'h3EF000, 1'b1);
    try(5'h18, 1'b1, 8'h20, 24'h3FF000, 1'b1);
    try(5'h11, 1'b0, 8'hC7, 24'h000000, 1'b1);
    try(5'h18, 1'b1, 8'h60, 24'h000000, 1'b0);
    // upper byte: invert, OTP locks 101, quad enable
    cmd(40'h06, 8);
    cmd({8'h01, 8'h00, 8'h6A}, 24);
    check(sw[15:8], 8'h6A, "upper byte");
    host.frame(40'h35, 8, 1, q);
    check(q, 8'h6A, "serial upper byte");
    host.frame(40'h05, 8, 1, q);
    check(q, 8'h00, "serial lower byte");
    // guard pin with lock mode 01
    @(posedge clk) wp_n <= 1'b0;
    cmd(40'h06, 8);
    cmd({8'h01, 8'h84, 8'h00}, 24);
    cmd(40'h06, 8);
    cmd({8'h01, 8'h88, 8'h00}, 24);
    check({rej_seen, wl}, 2'b11, "write under guard pin");
    check(sw[8:2], 7'h21, "bits under guard pin");
    @(posedge clk) wp_n <= 1'b1;
    cmd(40'h06, 8);
    cmd({8'h01, 8'h88, 8'h00}, 24);
    check(sw[8:2], 7'h22, "write with guard pin high");
    // lock modes 10 and 11 hold until a power cycle
    for (int m = 2; m < 4; m++)
    begin
      cmd(40'h06, 8);
      cmd({8'h01, m[0], 7'h00, 7'h00, m[1]}, 24);
      cmd(40'h06, 8);
      cmd({8'h01, 8'h04, 8'h00}, 24);
      check(rej_seen, 1'b1, "locked write");
      check(sw[8:2], {m[1], m[0], 5'h00}, "locked bits");
      reset_pulse();
      check(sw, 16'h0000, "power cycle");
    end
    // deep power-down ignores all but wake
    cmd(40'hB9, 8);
    check(dpd, 1'b1, "asleep");
    cmd(40'h06, 8);
    check(wl, 1'b0, "latch ignored asleep");
    cmd(40'hAB, 8);
    check(dpd, 1'b0, "awake");
    cmd(40'h06, 8);
    check(wl, 1'b1, "latch after wake");
    // one-byte status write leaves the upper byte alone
    cmd({8'h01, 8'h08}, 16);
    check({sw[15:2], wl}, 15'h0004, "one-byte status write");
    print_verdict();
  end
endmodule

`default_nettype wire
